/* File: design/acp_event_match.sv */
/*
 * Event comparator: one masked compare per event, each against the whole
 * handshake probe of one channel.
 * Assumes probes that are already registered; output is combinational.
 */
module acp_event_match (
    acp_probe_if.sink              probes_in,
    output logic [acp_pkg::NUM_EVT-1:0] hit_out
);

    // ------------------------------------------------------------------
    // per event compare
    // ------------------------------------------------------------------
    for (genvar i = 0; i < acp_pkg::NUM_EVT; i++) begin : g_evt
        logic [2:0] sel;

        // pick the channel probe and pad it to three bits
        always_comb begin
            sel = 3'h0;
            case (acp_pkg::EVT_CHAN[i])
                acp_pkg::CH_RD_ADDR: sel = {1'h0, probes_in.rd_addr};
                acp_pkg::CH_RD_DATA: sel = probes_in.rd_data;
                acp_pkg::CH_WR_ADDR: sel = {1'h0, probes_in.wr_addr};
                acp_pkg::CH_WR_DATA: sel = probes_in.wr_data;
                acp_pkg::CH_WR_RESP: sel = {1'h0, probes_in.wr_resp};
                default:             sel = 3'h0;
            endcase
        end

        // a single compare covers the whole channel
        assign hit_out[i] =
            ((sel ^ acp_pkg::EVT_VALUE[i]) & acp_pkg::EVT_MASK[i]) == 3'h0;
    end

endmodule : acp_event_match

/* File: design/acp_top.sv */
/*
 * AXI channel trigger probes: packs each channel's valid and ready, plus last
 * on the data channels, into one probe, detects channel events every cycle and ORs selected
 * events into a trigger strobe and, while armed or fired, a capture strobe, with a small arm/fire
 * sequencer and a count of captured cycles after the trigger.
 * Assumes the AXI handshake inputs are synchronous to ref_clk_in and the
 * enable and arm inputs are steady levels from a debug controller.
 */
module acp_top #(
    parameter int CAPT_CNT_W = acp_pkg::CAPT_CNT_W_DEF
) (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic                         ar_valid_in,
    input  wire logic                         ar_ready_in,
    input  wire logic                         r_valid_in,
    input  wire logic                         r_ready_in,
    input  wire logic                         r_last_in,
    input  wire logic                         aw_valid_in,
    input  wire logic                         aw_ready_in,
    input  wire logic                         w_valid_in,
    input  wire logic                         w_ready_in,
    input  wire logic                         w_last_in,
    input  wire logic                         b_valid_in,
    input  wire logic                         b_ready_in,
    input  wire logic                         arm_in,
    input  wire logic [acp_pkg::NUM_EVT-1:0]  trig_enable_in,
    input  wire logic [acp_pkg::NUM_EVT-1:0]  capt_enable_in,
    output logic [acp_pkg::ADDR_PROBE_W-1:0]  read_addr_handshake_probe_out,
    output logic [acp_pkg::DATA_PROBE_W-1:0]  read_data_handshake_probe_out,
    output logic [acp_pkg::ADDR_PROBE_W-1:0]  write_addr_handshake_probe_out,
    output logic [acp_pkg::DATA_PROBE_W-1:0]  write_data_handshake_probe_out,
    output logic [acp_pkg::ADDR_PROBE_W-1:0]  write_resp_handshake_probe_out,
    output logic [acp_pkg::NUM_EVT-1:0]       event_out,
    output logic                              trigger_out,
    output logic                              capture_out,
    output logic                              armed_out,
    output logic                              fired_out,
    output logic [CAPT_CNT_W-1:0]             capture_count_out
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (CAPT_CNT_W < 1 || CAPT_CNT_W > 32) begin : g_bad_cnt_w
        $error("acp_top: CAPT_CNT_W must lie between 1 and 32");
    end

    // ------------------------------------------------------------------
    // probe packing
    // ------------------------------------------------------------------
    acp_probe_if probes ();

    logic [acp_pkg::ADDR_PROBE_W-1:0] ra_probe_d, ra_probe_q;
    logic [acp_pkg::DATA_PROBE_W-1:0] rd_probe_d, rd_probe_q;
    logic [acp_pkg::ADDR_PROBE_W-1:0] wa_probe_d, wa_probe_q;
    logic [acp_pkg::DATA_PROBE_W-1:0] wd_probe_d, wd_probe_q;
    logic [acp_pkg::ADDR_PROBE_W-1:0] wr_probe_d, wr_probe_q;

    // concatenate each channel's handshake onto one probe
    always_comb begin
        ra_probe_d = acp_pkg::ADDR_PROBE_RST;
        rd_probe_d = acp_pkg::DATA_PROBE_RST;
        wa_probe_d = acp_pkg::ADDR_PROBE_RST;
        wd_probe_d = acp_pkg::DATA_PROBE_RST;
        wr_probe_d = acp_pkg::ADDR_PROBE_RST;
        ra_probe_d[acp_pkg::VALID_BIT] = ar_valid_in;
        ra_probe_d[acp_pkg::READY_BIT] = ar_ready_in;
        rd_probe_d[acp_pkg::VALID_BIT] = r_valid_in;
        rd_probe_d[acp_pkg::READY_BIT] = r_ready_in;
        rd_probe_d[acp_pkg::LAST_BIT]  = r_last_in;
        wa_probe_d[acp_pkg::VALID_BIT] = aw_valid_in;
        wa_probe_d[acp_pkg::READY_BIT] = aw_ready_in;
        wd_probe_d[acp_pkg::VALID_BIT] = w_valid_in;
        wd_probe_d[acp_pkg::READY_BIT] = w_ready_in;
        wd_probe_d[acp_pkg::LAST_BIT]  = w_last_in;
        wr_probe_d[acp_pkg::VALID_BIT] = b_valid_in;
        wr_probe_d[acp_pkg::READY_BIT] = b_ready_in;
    end

    // sample every probe on every rising clock edge
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ra_probe_q <= acp_pkg::ADDR_PROBE_RST;
            rd_probe_q <= acp_pkg::DATA_PROBE_RST;
            wa_probe_q <= acp_pkg::ADDR_PROBE_RST;
            wd_probe_q <= acp_pkg::DATA_PROBE_RST;
            wr_probe_q <= acp_pkg::ADDR_PROBE_RST;
        end else begin
            ra_probe_q <= ra_probe_d;
            rd_probe_q <= rd_probe_d;
            wa_probe_q <= wa_probe_d;
            wd_probe_q <= wd_probe_d;
            wr_probe_q <= wr_probe_d;
        end
    end

    assign probes.rd_addr = ra_probe_q;
    assign probes.rd_data = rd_probe_q;
    assign probes.wr_addr = wa_probe_q;
    assign probes.wr_data = wd_probe_q;
    assign probes.wr_resp = wr_probe_q;

    assign read_addr_handshake_probe_out  = ra_probe_q;
    assign read_data_handshake_probe_out  = rd_probe_q;
    assign write_addr_handshake_probe_out = wa_probe_q;
    assign write_data_handshake_probe_out = wd_probe_q;
    assign write_resp_handshake_probe_out = wr_probe_q;

    // ------------------------------------------------------------------
    // event compare
    // ------------------------------------------------------------------
    logic [acp_pkg::NUM_EVT-1:0] hit;

    acp_event_match u_match (
        .probes_in (probes.sink),
        .hit_out   (hit)
    );

    // ------------------------------------------------------------------
    // trigger sequencer, strobes and capture count
    // ------------------------------------------------------------------
    acp_pkg::acp_state_t         state_d, state_q;
    logic [acp_pkg::NUM_EVT-1:0] event_d, event_q;
    logic                        trig_d, trig_q;
    logic                        capt_d, capt_q;
    logic [CAPT_CNT_W-1:0]       count_d, count_q;
    logic                        trig_hit;
    logic                        capt_hit;

    // OR of enabled events across channels, then sequencing
    always_comb begin
        trig_hit = |(hit & trig_enable_in);
        capt_hit = |(hit & capt_enable_in);
        event_d  = hit;
        trig_d   = trig_hit;
        capt_d   = capt_hit && (state_q != acp_pkg::ST_IDLE);
        state_d  = state_q;
        count_d  = count_q;
        case (state_q)
            acp_pkg::ST_IDLE: begin
                count_d = '0;
                if (arm_in) begin
                    state_d = acp_pkg::ST_ARMED;
                end
            end
            acp_pkg::ST_ARMED: begin
                if (!arm_in) begin
                    state_d = acp_pkg::ST_IDLE;
                end else if (trig_hit) begin
                    state_d = acp_pkg::ST_FIRED;
                end
            end
            acp_pkg::ST_FIRED: begin
                if (!arm_in) begin
                    state_d = acp_pkg::ST_IDLE;
                    count_d = '0;
                end else if (capt_hit && count_q != '1) begin
                    count_d = count_q + 1'h1;  // saturates at all ones
                end
            end
            default: begin
                state_d = acp_pkg::ST_IDLE;
                count_d = '0;
            end
        endcase
    end

    // register sequencer and strobes
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= acp_pkg::ST_IDLE;
            event_q <= acp_pkg::EVT_RST;
            trig_q  <= 1'h0;
            capt_q  <= 1'h0;
            count_q <= '0;
        end else begin
            state_q <= state_d;
            event_q <= event_d;
            trig_q  <= trig_d;
            capt_q  <= capt_d;
            count_q <= count_d;
        end
    end

    assign event_out         = event_q;
    assign trigger_out       = trig_q;
    assign capture_out       = capt_q;
    assign armed_out         = (state_q == acp_pkg::ST_ARMED);
    assign fired_out         = (state_q == acp_pkg::ST_FIRED);
    assign capture_count_out = count_q;

    // ------------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------------
    logic [1:0] warm_q;

    // counts edges after reset so that past values are meaningful
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            warm_q <= 2'h0;
        end else if (warm_q != 2'h3) begin
            warm_q <= warm_q + 2'h1;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_RA_PROBE: assert property (warm_q == 2'h3 |->
        read_addr_handshake_probe_out == $past({ar_ready_in, ar_valid_in}))
        else $error("read address probe bits misplaced");
    AST_RD_PROBE: assert property (warm_q == 2'h3 |->
        read_data_handshake_probe_out == $past({r_last_in, r_ready_in, r_valid_in}))
        else $error("read data probe bits misplaced");
    AST_WA_PROBE: assert property (warm_q == 2'h3 |->
        write_addr_handshake_probe_out == $past({aw_ready_in, aw_valid_in}))
        else $error("write address probe bits misplaced");
    AST_WD_PROBE: assert property (warm_q == 2'h3 |->
        write_data_handshake_probe_out == $past({w_last_in, w_ready_in, w_valid_in}))
        else $error("write data probe bits misplaced");
    AST_WR_PROBE: assert property (warm_q == 2'h3 |->
        write_resp_handshake_probe_out == $past({b_ready_in, b_valid_in}))
        else $error("write response probe bits misplaced");
    AST_TRIG_OR: assert property (warm_q == 2'h3 |->
        trigger_out == |(event_out & $past(trig_enable_in)))
        else $error("trigger is not the OR of enabled events");
    AST_RA_END: assert property (warm_q == 2'h3 |->
        event_out[acp_pkg::EVT_RA_END] == ($past(ar_valid_in, 2) && $past(ar_ready_in, 2)))
        else $error("read address end event wrong");
    AST_RD_LAST: assert property (
        $rose(event_out[acp_pkg::EVT_RD_LAST]) |-> $past(read_data_handshake_probe_out) == 3'h7)
        else $error("last read beat event without probe 111");
    AST_RD_BEAT: assert property (warm_q == 2'h3 |->
        event_out[acp_pkg::EVT_RD_BEAT] == ($past(rd_probe_q) == 3'h3))
        else $error("non-last read beat event wrong");
    AST_WA_END: assert property (warm_q == 2'h3 |->
        event_out[acp_pkg::EVT_WA_END] == ($past(wa_probe_q) == 2'h3))
        else $error("write address end event wrong");
    AST_WD_LAST: assert property (warm_q == 2'h3 |->
        event_out[acp_pkg::EVT_WD_LAST] == ($past(w_valid_in, 2) && $past(w_ready_in, 2)
                                            && $past(w_last_in, 2)))
        else $error("last write beat event wrong");
    AST_WD_BEAT: assert property (warm_q == 2'h3 |->
        event_out[acp_pkg::EVT_WD_BEAT] == ($past(wd_probe_q) == 3'h3))
        else $error("non-last write beat event wrong");
    AST_WR_RESP: assert property (warm_q == 2'h3 |->
        event_out[acp_pkg::EVT_WR_RESP] == ($past(b_valid_in, 2) && $past(b_ready_in, 2)))
        else $error("write response event wrong");
    AST_EVT_EXCL: assert property (
        !(event_out[acp_pkg::EVT_RD_LAST] && event_out[acp_pkg::EVT_RD_BEAT]) &&
        !(event_out[acp_pkg::EVT_WD_LAST] && event_out[acp_pkg::EVT_WD_BEAT]))
        else $error("last and non-last beat flagged together");
    AST_FIRE: assert property (armed_out && arm_in && |(hit & trig_enable_in)
        |=> fired_out && trigger_out)
        else $error("armed sequencer missed its trigger");

    COV_RA_END:  cover property (event_out[acp_pkg::EVT_RA_END]);
    COV_RD_LAST: cover property (event_out[acp_pkg::EVT_RD_LAST]);
    COV_FIRE:    cover property (armed_out ##1 fired_out);
    COV_CAPT:    cover property (fired_out && capture_out ##1 capture_out);

endmodule : acp_top

/* File: pkg/acp_pkg.sv */
/*
 * Package for the AXI channel trigger probes: the widths of the channel
 * handshake probes, their bit positions, the event compare table, the
 * trigger state encoding and the values held after reset.
 * Assumes a single clock domain and AXI handshake inputs that are
 * synchronous to that clock.
 */
// Behaviour
// - read-address probe: valid bit0, ready bit1
// - read-data probe: valid bit0, ready bit1, last bit2
// - write-address probe: valid bit0, ready bit1
// - write-data probe: valid bit0, ready bit1, last bit2
// - write-response probe: valid bit0, ready bit1
// - one probe per channel, events ORable
// - read address end when probe is 11
// - last read beat end when probe 111
// - non-last read beat end when probe 011
// - write address end when probe is 11
// - last write beat end when probe 111
// - non-last write beat end when probe 011
package acp_pkg;

    // ------------------------------------------------------------------
    // probe widths and bit positions
    // ------------------------------------------------------------------
    localparam int ADDR_PROBE_W = 2;  // address and response channels
    localparam int DATA_PROBE_W = 3;  // data channels carry last
    localparam int VALID_BIT    = 0;
    localparam int READY_BIT    = 1;
    localparam int LAST_BIT     = 2;

    // ------------------------------------------------------------------
    // channels and events
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CH_RD_ADDR  = 3'h0,
        CH_RD_DATA  = 3'h1,
        CH_WR_ADDR  = 3'h2,
        CH_WR_DATA  = 3'h3,
        CH_WR_RESP  = 3'h4
    } acp_chan_t;

    localparam int NUM_EVT       = 7;
    localparam int EVT_RA_END    = 0;
    localparam int EVT_RD_LAST   = 1;
    localparam int EVT_RD_BEAT   = 2;
    localparam int EVT_WA_END    = 3;
    localparam int EVT_WD_LAST   = 4;
    localparam int EVT_WD_BEAT   = 5;
    localparam int EVT_WR_RESP   = 6;

    // compare value and care mask per event, on a probe padded to three bits
    localparam acp_chan_t EVT_CHAN [NUM_EVT] = '{
        CH_RD_ADDR, CH_RD_DATA, CH_RD_DATA, CH_WR_ADDR,
        CH_WR_DATA, CH_WR_DATA, CH_WR_RESP};
    localparam logic [2:0] EVT_VALUE [NUM_EVT] = '{
        3'h3, 3'h7, 3'h3, 3'h3, 3'h7, 3'h3, 3'h3};
    localparam logic [2:0] EVT_MASK  [NUM_EVT] = '{
        3'h3, 3'h7, 3'h7, 3'h3, 3'h7, 3'h7, 3'h3};

    // ------------------------------------------------------------------
    // trigger sequencer states, gray along idle, armed, fired
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ARMED = 2'h1,
        ST_FIRED = 2'h3
    } acp_state_t;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [ADDR_PROBE_W-1:0] ADDR_PROBE_RST = 2'h0;
    localparam logic [DATA_PROBE_W-1:0] DATA_PROBE_RST = 3'h0;
    localparam logic [NUM_EVT-1:0]      EVT_RST        = 7'h00;
    localparam int                      CAPT_CNT_W_DEF = 16;

endpackage : acp_pkg

/* File: pkg/acp_probe_if.sv */
/*
 * Interface carrying the five registered channel handshake probes from
 * the top of the probe block to its event comparator.
 * Assumes both ends sit in the same clock domain.
 */
interface acp_probe_if;

    // ------------------------------------------------------------------
    // channel probes
    // ------------------------------------------------------------------
    logic [acp_pkg::ADDR_PROBE_W-1:0] rd_addr;
    logic [acp_pkg::DATA_PROBE_W-1:0] rd_data;
    logic [acp_pkg::ADDR_PROBE_W-1:0] wr_addr;
    logic [acp_pkg::DATA_PROBE_W-1:0] wr_data;
    logic [acp_pkg::ADDR_PROBE_W-1:0] wr_resp;

    modport src  (output rd_addr, rd_data, wr_addr, wr_data, wr_resp);
    modport sink (input  rd_addr, rd_data, wr_addr, wr_data, wr_resp);

endinterface : acp_probe_if

/* File: sim/acp_axi_partner.sv */
/*
 * Model of the observed AXI manager and subordinate pair: one valid/ready
 * handshake per channel, bursts of one to four beats on the data channels,
 * ready prompt or stalling.
 * Assumes channel 0 read address, 1 read data, 2 write address,
 * 3 write data, 4 write response, all on the probe block's clock.
 */
module acp_axi_partner (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       slow_in,
    output logic [4:0]      valid_out,
    output logic [4:0]      ready_out,
    output logic [4:0]      last_out
);
    timeunit 1ns;
    timeprecision 100ps;

    int beat [5];
    int len  [5];

    // ------------------------------------------------------------------
    // handshakes, changed one step after each rising edge
    // ------------------------------------------------------------------
    initial begin
        valid_out = '0;
        ready_out = '0;
        last_out  = '0;
    end

    always @(posedge ref_clk_in or negedge rst_b_in) begin
        logic [4:0] v, r, l;
        if (!rst_b_in) begin
            valid_out = '0;
            ready_out = '0;
            last_out  = '0;
            beat      = '{default: 0};
        end else begin
            #1;
            v = valid_out;
            l = last_out;
            for (int c = 0; c < 5; c++) begin
                // valid holds until its last beat is taken, a new burst may follow
                if (v[c] && ready_out[c]) begin
                    beat[c]++;
                end
                if (!v[c] || beat[c] == len[c]) begin
                    beat[c] = 0;
                    v[c]    = ($urandom % 3 == 0);
                    len[c]  = (c == 1 || c == 3) ? int'($urandom % 4) + 1 : 1;
                end
                r[c] = slow_in ? 1'($urandom) : 1'b1;
                // a released last line shows the inverse of its old level
                l[c] = v[c] ? (beat[c] == len[c] - 1) : ~l[c];
            end
            // each line changes once per step
            valid_out = v;
            ready_out = r;
            last_out  = l;
        end
    end

endmodule : acp_axi_partner

/* File: sim/acp_top_bench.sv */
/*
 * Self-checking bench for the AXI channel trigger probes: a partner model
 * drives the handshakes, the bench predicts probes, events, strobes and
 * sequencer status into queues and a watcher compares them each cycle.
 * Assumes the package, probe interface and design files compiled first.
 */
module acp_top_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int CNT_W   = 3;     // small width so the count saturates
    localparam int MAX_CYC = 20000; // hang ceiling
    typedef struct packed {
        logic [6:0]          ev;
        logic                trig;
        logic                capt;
        acp_pkg::acp_state_t st;
        logic [CNT_W-1:0]    cnt;
    } acp_note_t;

    logic             ref_clk_in = 1'b0;
    logic             rst_b_in   = 1'b0;
    logic             slow       = 1'b0;
    logic             arm        = 1'b0;
    logic [6:0]       trig_en    = '0;
    logic [6:0]       capt_en    = '0;
    logic [4:0]       pv, pr, pl;
    logic [1:0]       ra_p, wa_p, wr_p;
    logic [2:0]       rd_p, wd_p;
    logic [6:0]       ev_o;
    logic             trig_o, capt_o, armed_o, fired_o;
    logic [CNT_W-1:0] cnt_o;
    logic [11:0]      pq [$];
    logic [6:0]       eq [$];
    acp_note_t        rq [$];
    int               mismatches = 0;
    int               n_tests    = 0;
    int               cyc        = 0;
    bit               mon_on     = 0;
    acp_pkg::acp_state_t st      = acp_pkg::ST_IDLE;
    logic [CNT_W-1:0] cnt        = '0;

    always #2 ref_clk_in = ~ref_clk_in;

    acp_axi_partner partner (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .slow_in(slow),
        .valid_out(pv), .ready_out(pr), .last_out(pl));

    acp_top #(.CAPT_CNT_W(CNT_W)) uut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .ar_valid_in(pv[0]), .ar_ready_in(pr[0]), .r_valid_in(pv[1]), .r_ready_in(pr[1]),
        .r_last_in(pl[1]), .aw_valid_in(pv[2]), .aw_ready_in(pr[2]), .w_valid_in(pv[3]),
        .w_ready_in(pr[3]), .w_last_in(pl[3]), .b_valid_in(pv[4]), .b_ready_in(pr[4]),
        .arm_in(arm), .trig_enable_in(trig_en), .capt_enable_in(capt_en),
        .read_addr_handshake_probe_out(ra_p), .read_data_handshake_probe_out(rd_p),
        .write_addr_handshake_probe_out(wa_p), .write_data_handshake_probe_out(wd_p),
        .write_resp_handshake_probe_out(wr_p), .event_out(ev_o), .trigger_out(trig_o),
        .capture_out(capt_o), .armed_out(armed_o), .fired_out(fired_o),
        .capture_count_out(cnt_o));

    // ------------------------------------------------------------------
    // compare, model and closing tasks
    // ------------------------------------------------------------------
    task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_vec(what, 16'(exp), 16'(got));
    endtask : check_bit

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // sequencer prediction for the edge that registers events of ev
    task automatic note_model(input logic [6:0] ev);
        acp_pkg::acp_state_t nx;
        logic [CNT_W-1:0]    nc;
        nx = st;
        nc = cnt;
        if (!arm) begin
            nx = acp_pkg::ST_IDLE;
            nc = '0;
        end else if (st == acp_pkg::ST_IDLE) begin
            nx = acp_pkg::ST_ARMED;
        end else if (st == acp_pkg::ST_ARMED && |(ev & trig_en)) begin
            nx = acp_pkg::ST_FIRED;
        end else if (st == acp_pkg::ST_FIRED && |(ev & capt_en) && cnt != '1) begin
            nc = cnt + 1'b1;
        end
        rq.push_back('{ev, |(ev & trig_en), |(ev & capt_en) && st != acp_pkg::ST_IDLE,
                       nx, nc});
        st  = nx;
        cnt = nc;
    endtask : note_model

    task automatic step(input int arm_mode);
        @(posedge ref_clk_in);
        #1;
        if (arm_mode < 2 && $urandom % 8 == 0) trig_en = 7'($urandom);
        if (arm_mode < 2 && $urandom % 8 == 0) capt_en = 7'($urandom);
        if (arm_mode == 1 && $urandom % 24 == 0) arm = ~arm;
    endtask : step

    task automatic do_reset(input int hold);
        @(posedge ref_clk_in);
        #1;
        mon_on = 0;
        pq.delete();
        rq.delete();
        eq.delete();
        st       = acp_pkg::ST_IDLE;
        cnt      = '0;
        arm      = 1'b0;
        rst_b_in = 1'b0;
        repeat (hold) begin
            @(negedge ref_clk_in);
            check_vec("probes in reset", 16'h0000,
                      16'({ra_p, rd_p, wa_p, wd_p, wr_p}));
            check_vec("status in reset", 16'h0000,
                      16'({ev_o, trig_o, capt_o, armed_o, fired_o, cnt_o}));
        end
        @(posedge ref_clk_in);
        #1;
        rst_b_in = 1'b1;
        mon_on   = 1;
        repeat (2) step(0);
    endtask : do_reset

    task automatic run_phase(input string name, input bit slw, input int mode, input int n);
        slow = slw;
        repeat (n) step(mode);
        $display("test %s done, mismatches %0d", name, mismatches);
    endtask : run_phase

    // ------------------------------------------------------------------
    // notes taken at each edge, checked at the following falling edge
    // ------------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            mismatches++;
            $display("BAD run length expected below %0d seen %0d", MAX_CYC, cyc);
            stop_test();
        end else if (mon_on && rst_b_in) begin
            if (eq.size() > 0) note_model(eq.pop_front());
            pq.push_back({pr[0], pv[0], pl[1], pr[1], pv[1], pr[2], pv[2],
                          pl[3], pr[3], pv[3], pr[4], pv[4]});
            eq.push_back({pv[4] & pr[4], pv[3] & pr[3] & ~pl[3], pv[3] & pr[3] & pl[3],
                          pv[2] & pr[2], pv[1] & pr[1] & ~pl[1], pv[1] & pr[1] & pl[1],
                          pv[0] & pr[0]});
        end
    end

    always @(negedge ref_clk_in) begin
        logic [11:0] p;
        acp_note_t   n;
        if (pq.size() > 0) begin
            p = pq.pop_front();
            check_vec("read addr probe", 16'(p[11:10]), 16'(ra_p));
            check_vec("read data probe", 16'(p[9:7]), 16'(rd_p));
            check_vec("write addr probe", 16'(p[6:5]), 16'(wa_p));
            check_vec("write data probe", 16'(p[4:2]), 16'(wd_p));
            check_vec("write resp probe", 16'(p[1:0]), 16'(wr_p));
        end
        if (rq.size() > 0) begin
            n = rq.pop_front();
            check_vec("events", 16'(n.ev), 16'(ev_o));
            check_bit("trigger", n.trig, trig_o);
            check_bit("capture", n.capt, capt_o);
            check_bit("armed", n.st == acp_pkg::ST_ARMED, armed_o);
            check_bit("fired", n.st == acp_pkg::ST_FIRED, fired_o);
            check_vec("capture count", 16'(n.cnt), 16'(cnt_o));
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'ha9e4));
        do_reset(10);
        run_phase("prompt traffic", 1'b0, 0, 600);
        run_phase("stalled traffic", 1'b1, 0, 600);
        run_phase("random arming", 1'b1, 1, 1500);
        // each event alone fires the sequencer once the bench raises arm, count saturates
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk_in);
            #1;
            arm     = 1'b0;
            trig_en = 7'h01 << i;
            capt_en = 7'h7f;
            repeat (2) step(2);
            arm = 1'b1;
            repeat (60) step(2);
        end
        $display("test single event fire done, mismatches %0d", mismatches);
        do_reset(3);
        run_phase("after second reset", 1'b0, 1, 600);
        stop_test();
    end

endmodule : acp_top_bench
